// ===== design/sch_cfg.svh
// Constants of the serial controller host bus interface.
// Assumes inclusion by bare name from package and modules.
`ifndef SCH_CFG_SVH
`define SCH_CFG_SVH

// ----------------------------------------
// Source counts
// ----------------------------------------
`define SCH_NSER 6
`define SCH_NDMA 4

// ----------------------------------------
// Bus configuration register fields
// ----------------------------------------
`define SCH_BCR_SHL_BIT 0
`define SCH_BCR_SWEN_BIT 1
`define SCH_BCR_SWSEL_BIT 2

// ----------------------------------------
// Serial core register numbers and fields
// ----------------------------------------
`define SCH_SER_PTR_REG 4'h0
`define SCH_SER_IE_REG 4'h1
`define SCH_SER_VEC_REG 4'h2
`define SCH_SER_DATA_REG 4'h8
`define SCH_SER_MIC_REG 4'h9
`define SCH_SER_MIE_BIT 3
`define SCH_SER_VIS_BIT 0
`define SCH_SER_SHL 2'h2

// ----------------------------------------
// DMA core register numbers and fields
// ----------------------------------------
`define SCH_DMA_PTR_REG 5'h00
`define SCH_DMA_IE_REG 5'h01
`define SCH_DMA_VEC_REG 5'h02
`define SCH_DMA_IUSCLR_REG 5'h03
`define SCH_DMA_MIE_BIT 7
`define SCH_DMA_VIS_BIT 6

// ----------------------------------------
// Host controller register map and fields
// ----------------------------------------
`define SCH_H_CMD 8'h00
`define SCH_H_STAT 8'h04
`define SCH_H_CTRL 8'h08
`define SCH_CMD_RD 8
`define SCH_CMD_CORE 9
`define SCH_CMD_CHAN 10
`define SCH_CMD_AS 11
`define SCH_CMD_ACK 12
`define SCH_CMD_ADDR 16

`endif

// ===== design/sch_pkg.sv
// Types of the host bus interface: bytes for the device end, sequencer states for the host end.
// Assumes sch_cfg.svh is on the include path.
`default_nettype none
`include "sch_cfg.svh"
package sch_pkg;
  typedef logic [7:0] sch_byte_t;
  typedef enum logic [1:0] {SCH_IDLE, SCH_ADDR, SCH_STRB, SCH_DATA}
    sch_hstate_e;
endpackage
`default_nettype wire

// ===== design/sch_bus_if.sv
// Pin-level bus between the host end and the device end.
// Assumes both ends run on clk_sys; resolves the shared data lines.
`timescale 1ns/1ps
`default_nettype none
interface sch_bus_if;
  logic as_n;
  logic rd_n;
  logic wr_n;
  logic irq_acknowledge_in_n;
  logic core_select_pin;
  logic channel_select_pin;
  logic [15:0] host_ad;
  logic host_ad_oe;
  logic [15:0] dev_ad;
  logic dev_ad_oe;
  logic [15:0] ad;
  logic int_n;
  logic chain_enable_in;
  logic chain_enable_out;
  // Undriven lines read as pulled up
  assign ad = dev_ad_oe ? dev_ad : (host_ad_oe ? host_ad : '1);
  modport dev (
    input as_n, rd_n, wr_n, irq_acknowledge_in_n, core_select_pin,
    input channel_select_pin, ad, chain_enable_in,
    output dev_ad, dev_ad_oe, int_n, chain_enable_out
  );
  modport host (
    output as_n, rd_n, wr_n, irq_acknowledge_in_n, core_select_pin,
    output channel_select_pin, host_ad, host_ad_oe, chain_enable_in,
    input ad, int_n, chain_enable_out
  );
endinterface
`default_nettype wire

// ===== design/sch_host_end.sv
// Host end: takes orders over AHB-Lite and runs bus cycles on the pins.
// Assumes a single AHB-Lite master and the device on the same clock.
`timescale 1ns/1ps
`default_nettype none
module sch_host_end
  import sch_pkg::*;
(
  input wire logic clk_sys, // System clock
  input wire logic rst, // Async reset, active high
  input wire logic hsel, // Slave select
  input wire logic [31:0] haddr, // Address
  input wire logic [1:0] htrans, // Transfer type
  input wire logic hwrite, // Write flag
  input wire logic [2:0] hsize, // Transfer size
  input wire logic [31:0] hwdata, // Write data
  input wire logic hready, // Bus ready
  output logic hreadyout, // Slave ready
  output logic [31:0] hrdata, // Read data
  output logic hresp, // Response, always OKAY
  sch_bus_if.host bus // Device pins
);
  sch_hstate_e st_q;
  logic [31:0] cmd_q;
  logic [7:0] rdata_q;
  logic iei_q;
  logic wr_pend_q;
  logic [7:0] a_q;
  logic [31:0] hrdata_q;
  logic op_rd, op_ack, op_wr;

  // ----------------------------------------
  // AHB-Lite slave
  // ----------------------------------------
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_q;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wr_pend_q <= 1'b0;
      a_q <= '0;
      hrdata_q <= '0;
    end else begin
      wr_pend_q <= 1'b0;
      if (hsel && htrans[1] && hready) begin
        wr_pend_q <= hwrite;
        a_q <= haddr[7:0];
        unique case (haddr[7:0])
          `SCH_H_CMD: hrdata_q <= cmd_q;
          `SCH_H_STAT: hrdata_q <= {16'h0, rdata_q, 6'h0, ~bus.int_n,
                                    st_q != SCH_IDLE};
          `SCH_H_CTRL: hrdata_q <= {31'h0, iei_q};
          default: hrdata_q <= '0;
        endcase
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      iei_q <= 1'b1;
    end else if (wr_pend_q && a_q == `SCH_H_CTRL) begin
      iei_q <= hwdata[0];
    end
  end

  // ----------------------------------------
  // Bus cycle sequencer
  // ----------------------------------------
  // Orders that arrive while busy are dropped; software polls busy
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_q <= SCH_IDLE;
      cmd_q <= '0;
      rdata_q <= '0;
    end else begin
      unique case (st_q)
        SCH_IDLE: begin
          if (wr_pend_q && a_q == `SCH_H_CMD) begin
            cmd_q <= hwdata;
            st_q <= hwdata[`SCH_CMD_AS] ? SCH_ADDR : SCH_STRB;
          end
        end
        SCH_ADDR: st_q <= SCH_STRB;
        SCH_STRB: st_q <= (op_rd || op_ack) ? SCH_DATA : SCH_IDLE;
        SCH_DATA: begin
          rdata_q <= bus.ad[7:0];
          st_q <= SCH_IDLE;
        end
      endcase
    end
  end

  assign op_ack = cmd_q[`SCH_CMD_ACK];
  assign op_rd = cmd_q[`SCH_CMD_RD] && !op_ack;
  assign op_wr = !cmd_q[`SCH_CMD_RD] && !op_ack;

  // Pointer, then data: without address cycles, software issues two orders for one register
  assign bus.as_n = !(st_q == SCH_ADDR);
  assign bus.wr_n = !(st_q == SCH_STRB && op_wr);
  assign bus.rd_n = !(st_q == SCH_STRB && op_rd);
  assign bus.irq_acknowledge_in_n = !(st_q == SCH_STRB && op_ack);
  assign bus.host_ad_oe = st_q == SCH_ADDR || (st_q == SCH_STRB && op_wr);
  assign bus.host_ad = (st_q == SCH_ADDR) ?
    {8'h0, cmd_q[`SCH_CMD_ADDR +: 8]} : {8'h0, cmd_q[7:0]};
  assign bus.core_select_pin = cmd_q[`SCH_CMD_CORE];
  assign bus.channel_select_pin = cmd_q[`SCH_CMD_CHAN];
  assign bus.chain_enable_in = iei_q;

endmodule // sch_host_end
`default_nettype wire

// ===== design/sch_dev_end.sv
// Device end: bus interface, register addressing, lanes and interrupts.
// Assumes host strobes are one-cycle pulses synchronous to clk_sys.
//
// The register addresses and register access over AHB-Lite are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module sch_dev_end
  import sch_pkg::*;
#(
  parameter int NDMA = `SCH_NDMA
)
(
  input wire logic clk_sys, // System clock
  input wire logic rst, // Async reset, active high
  sch_bus_if.dev bus, // Host bus pins
  input wire logic [1:0] rx_evt, // Receive event per channel
  input wire logic [1:0] ext_evt, // External/status event per channel
  input wire logic [1:0] tx_take, // Transmitter takes buffered byte
  input wire logic [1:0][7:0] rx_data, // Receive byte per channel
  output logic [1:0] tx_full, // Transmit buffer holds a byte
  output logic [1:0][7:0] tx_data, // Transmit byte per channel
  input wire logic [NDMA-1:0] dma_evt, // DMA channel events
  input wire logic dma_to_mem, // Drive one DMA byte to memory
  input wire logic [7:0] dma_out_byte, // Byte for that cycle
  input wire logic dma_from_mem, // Take one DMA byte from bus
  input wire logic dma_addr0, // DMA address bit zero
  output logic [7:0] dma_in_byte, // Byte taken from bus
  output logic dma_in_valid // Pulse with taken byte
);
  localparam int NSRC = `SCH_NSER + NDMA;

  if (NDMA < 1 || NDMA > 4) begin : g_chk
    $error("NDMA must be 1 to 4");
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [4:0] dec_addr(input logic [5:0] a,
                                          input logic shl);
    dec_addr = shl ? a[5:1] : a[4:0];
  endfunction

  // Lowest index has the highest priority
  function automatic logic [3:0] first_set(input logic [NSRC-1:0] v);
    first_set = '0;
    for (int i = NSRC - 1; i >= 0; i--) begin
      if (v[i]) begin
        first_set = 4'(i);
      end
    end
  endfunction

  logic wr_stb, rd_stb, ack_stb, as_stb, ser_sel, ch, reg_wr;
  logic [7:0] wdata;
  assign wr_stb = !bus.wr_n;
  assign rd_stb = !bus.rd_n;
  assign ack_stb = !bus.irq_acknowledge_in_n;
  assign as_stb = !bus.as_n;
  assign ser_sel = bus.core_select_pin;
  assign ch = bus.channel_select_pin;
  assign wdata = bus.ad[7:0];

  // ----------------------------------------
  // Bus configuration
  // ----------------------------------------
  logic [7:0] bcr_q;
  logic bcr_done_q, mux_q, as_seen_q;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      bcr_q <= '0;
      bcr_done_q <= 1'b0;
      mux_q <= 1'b0;
      as_seen_q <= 1'b0;
    end else begin
      if (as_stb) begin
        as_seen_q <= 1'b1;
      end
      if (wr_stb && !bcr_done_q) begin
        bcr_q <= wdata;
        bcr_done_q <= 1'b1;
        mux_q <= as_seen_q || as_stb;
      end
    end
  end
  // Configuration write is consumed and never reaches a register
  assign reg_wr = wr_stb && bcr_done_q;

  // ----------------------------------------
  // Addressing
  // ----------------------------------------
  logic [5:0] addr_q;
  logic [3:0] ser_ptr_q, ser_tgt;
  logic [4:0] dma_ptr_q, dma_tgt, ser_dec;
  logic ser_armed_q, dma_armed_q, ser_shl_q;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      addr_q <= '0;
    end else if (as_stb) begin
      addr_q <= bus.ad[5:0];
    end
  end

  always_comb begin
    ser_dec = dec_addr(addr_q, ser_shl_q);
    ser_tgt = ser_armed_q ? ser_ptr_q : `SCH_SER_PTR_REG;
    dma_tgt = dma_armed_q ? dma_ptr_q : `SCH_DMA_PTR_REG;
    if (mux_q) begin
      ser_tgt = ser_dec[3:0];
      dma_tgt = dec_addr(addr_q, bcr_q[`SCH_BCR_SHL_BIT]);
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ser_ptr_q <= '0;
      ser_armed_q <= 1'b0;
      dma_ptr_q <= '0;
      dma_armed_q <= 1'b0;
    end else if (!mux_q && (reg_wr || rd_stb)) begin
      if (ser_sel) begin
        if (ser_armed_q) begin
          ser_armed_q <= 1'b0;
          ser_ptr_q <= '0;
        end else if (reg_wr) begin
          ser_ptr_q <= wdata[3:0];
          ser_armed_q <= 1'b1;
        end
      end else begin
        if (dma_armed_q) begin
          dma_armed_q <= 1'b0;
          dma_ptr_q <= '0;
        end else if (reg_wr) begin
          dma_ptr_q <= wdata[4:0];
          dma_armed_q <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------
  // Register storage
  // ----------------------------------------
  sch_byte_t ser_reg_q [2][16];
  sch_byte_t dma_reg_q [32];
  sch_byte_t ser_vec_q, dma_vec_q;
  logic [5:0] ser_ie_q;
  logic [NDMA-1:0] dma_ie_q;
  logic ser_mie_q, ser_vis_q, dma_mie_q, dma_vis_q;
  logic ser_wr, dma_wr;
  assign ser_wr = reg_wr && ser_sel;
  assign dma_wr = reg_wr && !ser_sel;

  // Plain storage, no reset; control bits live in flops below
  always_ff @(posedge clk_sys) begin
    if (ser_wr) begin
      ser_reg_q[ch][ser_tgt] <= wdata;
    end
    if (dma_wr) begin
      dma_reg_q[dma_tgt] <= wdata;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ser_shl_q <= 1'b0;
      ser_ie_q <= '0;
      ser_mie_q <= 1'b0;
      ser_vis_q <= 1'b0;
      ser_vec_q <= '0;
    end else if (ser_wr) begin
      if (mux_q && ser_tgt == `SCH_SER_PTR_REG) begin
        ser_shl_q <= wdata[1:0] == `SCH_SER_SHL;
      end
      if (ser_tgt == `SCH_SER_IE_REG) begin
        ser_ie_q[ch*3 +: 3] <= wdata[2:0];
      end
      if (ser_tgt == `SCH_SER_VEC_REG) begin
        ser_vec_q <= wdata;
      end
      if (ser_tgt == `SCH_SER_MIC_REG) begin
        ser_mie_q <= wdata[`SCH_SER_MIE_BIT];
        ser_vis_q <= wdata[`SCH_SER_VIS_BIT];
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      dma_ie_q <= '0;
      dma_mie_q <= 1'b0;
      dma_vis_q <= 1'b0;
      dma_vec_q <= '0;
    end else if (dma_wr) begin
      if (dma_tgt == `SCH_DMA_IE_REG) begin
        dma_ie_q <= wdata[NDMA-1:0];
        dma_mie_q <= wdata[`SCH_DMA_MIE_BIT];
        dma_vis_q <= wdata[`SCH_DMA_VIS_BIT];
      end
      if (dma_tgt == `SCH_DMA_VEC_REG) begin
        dma_vec_q <= wdata;
      end
    end
  end

  // ----------------------------------------
  // Transmit buffers
  // ----------------------------------------
  logic [1:0] tx_empt;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      tx_full <= '0;
      tx_data <= '0;
    end else begin
      for (int c = 0; c < 2; c++) begin
        if (tx_take[c]) begin
          tx_full[c] <= 1'b0;
        end
        // Write in the same cycle as a take keeps the buffer full
        if (ser_wr && ser_tgt == `SCH_SER_DATA_REG && ch == c[0]) begin
          tx_full[c] <= 1'b1;
          tx_data[c] <= wdata;
        end
      end
    end
  end
  assign tx_empt = tx_take & tx_full;

  // ----------------------------------------
  // Interrupt chain
  // ----------------------------------------
  logic [NSRC-1:0] ip_q, ius_q, en_v, set_v, req_v;
  logic [3:0] k_req, k_ius;
  logic any_req, ack_take, blk;

  always_comb begin
    en_v = {dma_ie_q & {NDMA{dma_mie_q}},
            ser_ie_q & {6{ser_mie_q}}};
    // Serial events only land on enabled sources
    set_v = {dma_evt, {ext_evt[1], tx_empt[1], rx_evt[1],
             ext_evt[0], tx_empt[0], rx_evt[0]} & ser_ie_q};
    blk = 1'b0;
    for (int i = 0; i < NSRC; i++) begin
      blk = blk | ius_q[i];
      req_v[i] = ip_q[i] && en_v[i] && !blk;
    end
  end

  assign any_req = |req_v;
  assign k_req = first_set(req_v);
  assign k_ius = first_set(ius_q);
  assign ack_take = ack_stb && bus.chain_enable_in && any_req;
  assign bus.int_n = !(bus.chain_enable_in && any_req);
  assign bus.chain_enable_out = bus.chain_enable_in && !(|ius_q);

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ip_q <= '0;
    end else begin
      for (int i = 0; i < NSRC; i++) begin
        // New event beats the clear by acknowledge
        if (set_v[i]) begin
          ip_q[i] <= 1'b1;
        end else if (ack_take && k_req == 4'(i)) begin
          ip_q[i] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ius_q <= '0;
    end else begin
      if (dma_wr && dma_tgt == `SCH_DMA_IUSCLR_REG && |ius_q) begin
        ius_q[k_ius] <= 1'b0;
      end
      if (ack_take) begin
        ius_q[k_req] <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Read data, vector and DMA lanes
  // ----------------------------------------
  sch_byte_t rd_byte, vec;
  logic [3:0] k_dma;
  assign k_dma = k_req - 4'(`SCH_NSER);

  always_comb begin
    if (k_req < 4'(`SCH_NSER)) begin
      vec = ser_vis_q ? {ser_vec_q[7:4], k_req[2:0], ser_vec_q[0]}
                      : ser_vec_q;
    end else begin
      vec = dma_vis_q ? {dma_vec_q[7:3], k_dma[1:0], dma_vec_q[0]}
                      : dma_vec_q;
    end
    if (ser_sel) begin
      unique case (ser_tgt)
        `SCH_SER_PTR_REG: rd_byte = {6'h0, !tx_full[ch], ip_q[ch*3]};
        `SCH_SER_IE_REG, `SCH_SER_MIC_REG: rd_byte = '0;
        `SCH_SER_VEC_REG: rd_byte = ser_vec_q;
        `SCH_SER_DATA_REG: rd_byte = rx_data[ch];
        default: rd_byte = ser_reg_q[ch][ser_tgt];
      endcase
    end else begin
      unique case (dma_tgt)
        `SCH_DMA_PTR_REG: rd_byte = 8'(ip_q[NSRC-1:`SCH_NSER]);
        `SCH_DMA_IE_REG: rd_byte = {dma_mie_q, dma_vis_q,
                                    6'(dma_ie_q)};
        `SCH_DMA_VEC_REG: rd_byte = dma_vec_q;
        default: rd_byte = dma_reg_q[dma_tgt];
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      bus.dev_ad <= '0;
      bus.dev_ad_oe <= 1'b0;
    end else begin
      bus.dev_ad_oe <= rd_stb || ack_take || dma_to_mem;
      if (rd_stb) begin
        bus.dev_ad <= {rd_byte, rd_byte};
      end else if (ack_take) begin
        bus.dev_ad <= {vec, vec};
      end else if (dma_to_mem) begin
        bus.dev_ad <= {dma_out_byte, dma_out_byte};
      end
    end
  end

  logic upper;
  // Lane choice only matters while swapping is enabled
  assign upper = bcr_q[`SCH_BCR_SWEN_BIT] &&
    (bcr_q[`SCH_BCR_SWSEL_BIT] == dma_addr0);

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      dma_in_byte <= '0;
      dma_in_valid <= 1'b0;
    end else begin
      dma_in_valid <= dma_from_mem;
      if (dma_from_mem) begin
        dma_in_byte <= upper ? bus.ad[15:8] : bus.ad[7:0];
      end
    end
  end

endmodule // sch_dev_end
`default_nettype wire

// ===== dv/sch_bus_monitor.sv
// Checker on the pins joining host end and device end.
// Assumes the bench top instantiates it beside sch_bus_if.
`timescale 1ns/1ps
`default_nettype none
module sch_bus_monitor (
  input wire logic clk_sys, // System clock
  input wire logic rst, // Async reset
  input wire logic rd_n, // Read strobe
  input wire logic wr_n, // Write strobe
  input wire logic irq_acknowledge_in_n, // Acknowledge strobe
  input wire logic host_ad_oe, // Host drives lines
  input wire logic [15:0] dev_ad, // Device drive value
  input wire logic dev_ad_oe, // Device drives lines
  input wire logic int_n, // Interrupt request
  input wire logic chain_enable_in, // Chain input
  input wire logic chain_enable_out // Chain output
);
  // ----------------------------------------
  // Pin relations
  // ----------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  lanes_replicated_a: assert property (
    dev_ad_oe |-> dev_ad[15:8] == dev_ad[7:0])
    else $error("Byte lanes differ");
  read_answer_a: assert property (!rd_n |=> dev_ad_oe)
    else $error("Read not answered");
  drive_once_a: assert property (dev_ad_oe |=> !dev_ad_oe)
    else $error("Drive held too long");
  write_quiet_a: assert property (!wr_n |=> !dev_ad_oe)
    else $error("Drive after write");
  no_clash_a: assert property (dev_ad_oe |-> !host_ad_oe)
    else $error("Both ends drive");
  chain_gate_a: assert property (!int_n |-> chain_enable_in)
    else $error("Request with chain low");
  chain_pass_a: assert property (
    !chain_enable_in |-> !chain_enable_out)
    else $error("Chain out high with chain in low");
  ack_refused_a: assert property (
    !irq_acknowledge_in_n && !chain_enable_in |=> !dev_ad_oe)
    else $error("Refused acknowledge answered");
  ack_serves_a: assert property (
    !irq_acknowledge_in_n && !int_n && chain_enable_in
    |=> dev_ad_oe && !chain_enable_out)
    else $error("Acknowledge not served");
endmodule // sch_bus_monitor
`default_nettype wire

// ===== dv/serial_ctrl_host_bus_interface_test.sv
// Bench: AHB-Lite master drives the host end facing the device end.
// Assumes design files and sch_cfg.svh are on the include path.
`timescale 1ns/1ps
`default_nettype none
`include "sch_cfg.svh"
module serial_ctrl_host_bus_interface_test
  import sch_pkg::*;
;
  localparam logic [4:0] RD = 5'h01, SER = 5'h02, CHB = 5'h04;
  localparam logic [4:0] AS = 5'h08, ACK = 5'h10;
  logic clk_sys = 0, rst = 1, hsel = 0, hwrite = 0, hreadyout, hresp;
  logic [1:0] htrans = 0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, s;
  logic [1:0] rx_evt = 0, ext_evt = 0, tx_take = 0, tx_full;
  logic [1:0][7:0] rx_data = 16'hc33c, tx_data;
  logic [`SCH_NDMA-1:0] dma_evt = 0;
  logic dma_to_mem = 0, dma_from_mem = 0, dma_addr0 = 0, dma_in_valid;
  sch_byte_t dma_out_byte = 8'h5a, dma_in_byte, b;
  int fail_count = 0, n_checks = 0, cyc = 0;
  always #5 clk_sys = ~clk_sys;
  sch_bus_if sch_bus_if_inst ();
  sch_host_end sch_host_end_inst (.clk_sys, .rst, .hsel, .haddr,
    .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hreadyout,
    .hrdata, .hresp, .bus(sch_bus_if_inst));
  sch_dev_end #(.NDMA(`SCH_NDMA)) sch_dev_end_inst (.clk_sys, .rst,
    .bus(sch_bus_if_inst), .rx_evt, .ext_evt, .tx_take, .rx_data,
    .tx_full, .tx_data, .dma_evt, .dma_to_mem, .dma_out_byte,
    .dma_from_mem, .dma_addr0, .dma_in_byte, .dma_in_valid);
  sch_bus_monitor sch_bus_monitor_inst (.clk_sys, .rst,
    .rd_n(sch_bus_if_inst.rd_n), .wr_n(sch_bus_if_inst.wr_n),
    .irq_acknowledge_in_n(sch_bus_if_inst.irq_acknowledge_in_n),
    .host_ad_oe(sch_bus_if_inst.host_ad_oe),
    .dev_ad(sch_bus_if_inst.dev_ad), .dev_ad_oe(sch_bus_if_inst.dev_ad_oe),
    .int_n(sch_bus_if_inst.int_n),
    .chain_enable_in(sch_bus_if_inst.chain_enable_in),
    .chain_enable_out(sch_bus_if_inst.chain_enable_out));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task print_verdict();
    $display("Checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    hsel <= 1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= a;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    hsel <= 0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    s = hrdata;
  endtask
  // Polls busy with no count of its own; only the ceiling ends a hang
  task idle();
    do ahb(0, `SCH_H_STAT, 0); while (s[0] !== 1'b0);
    b = s[15:8];
  endtask
  // One pin cycle; waits for the host end to go idle
  task pin(input logic [4:0] f, input logic [7:0] a, input logic [7:0] d);
    ahb(1, `SCH_H_CMD, {8'h0, a, 3'h0, f, d});
    idle();
  endtask
  // Address cycle puts {00, a8} on the lines while DMA samples them
  task lane(input logic a0, input logic [7:0] e);
    ahb(1, `SCH_H_CMD, {8'h0, 8'ha8, 3'h0, SER | RD | AS, 8'h00});
    dma_addr0 <= a0;
    dma_from_mem <= 1;
    @(posedge clk_sys);
    dma_from_mem <= 0;
    #1;
    chk("dma valid", 8'h01, {7'h0, dma_in_valid});
    chk("dma lane", e, dma_in_byte);
    idle();
  endtask
  task wr2(input logic [4:0] f, input logic [7:0] p, input logic [7:0] d);
    pin(f, 0, p);
    pin(f, 0, d);
  endtask
  task rd2(input string nm, input logic [4:0] f, input logic [7:0] p,
           input logic [7:0] e);
    pin(f, 0, p);
    pin(f | RD, 0, 0);
    chk(nm, e, b);
  endtask
  task st(input string nm, input logic e);
    ahb(0, `SCH_H_STAT, 0);
    chk(nm, {7'h0, e}, {7'h0, s[1]});
  endtask
  task chain(input string nm, input logic e);
    chk(nm, {7'h0, e}, {7'h0, sch_bus_if_inst.chain_enable_out});
  endtask
  task reset();
    rst <= 1;
    repeat (8) @(posedge clk_sys);
    rst <= 0;
  endtask
  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  // Ceiling well above the few hundred cycles the sequence needs
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      print_verdict();
    end
  end
  initial begin
    reset();
    pin(5'h0, 0, 8'h06);
    dma_evt <= 4'h2;
    @(posedge clk_sys);
    dma_evt <= 0;
    pin(RD, 0, 0);
    chk("dma pending", 8'h02, b);
    st("no request", 0);
    wr2(0, 8'h01, 8'h81);
    rd2("dma enables", 0, 8'h01, 8'h81);
    wr2(0, 8'h02, 8'h20);
    dma_evt <= 4'h1;
    @(posedge clk_sys);
    dma_evt <= 0;
    st("dma request", 1);
    ahb(1, `SCH_H_CTRL, 0);
    st("chain in low", 0);
    pin(ACK, 0, 0);
    chk("refused ack", 8'hff, b);
    ahb(1, `SCH_H_CTRL, 1);
    pin(ACK, 0, 0);
    chk("dma vector", 8'h20, b);
    chain("chain held", 0);
    wr2(0, 8'h03, 8'h00);
    chain("chain freed", 1);
    wr2(SER, 8'h01, 8'h07);
    wr2(SER, 8'h09, 8'h09);
    wr2(SER, 8'h02, 8'h40);
    rd2("serial enables", SER, 8'h01, 8'h00);
    wr2(SER, 8'h08, 8'ha5);
    chk("tx byte", 8'ha5, tx_data[0]);
    chk("tx full", 8'h01, {7'h0, tx_full[0]});
    rd2("rx byte", SER, 8'h08, 8'h3c);
    tx_take <= 2'b01;
    ext_evt <= 2'b01;
    rx_evt <= 2'b10;
    @(posedge clk_sys);
    tx_take <= 0;
    ext_evt <= 0;
    rx_evt <= 0;
    st("tx request", 1);
    pin(SER | ACK, 0, 0);
    chk("serial vector", 8'h42, b);
    chain("serial chain", 0);
    st("lower held", 0);
    dma_to_mem <= 1;
    @(posedge clk_sys);
    dma_to_mem <= 0;
    #1;
    chk("lane high", 8'h5a, sch_bus_if_inst.ad[15:8]);
    chk("lane low", 8'h5a, sch_bus_if_inst.ad[7:0]);
    lane(0, 8'ha8);
    lane(1, 8'h00);
    reset();
    pin(AS, 0, 8'h01);
    pin(SER | RD | AS, 8'h08, 0);
    chk("mux a", 8'h3c, b);
    pin(SER | RD | AS | CHB, 8'h08, 0);
    chk("mux b", 8'hc3, b);
    lane(1, 8'ha8);
    pin(AS, 8'h04, 8'h33);
    pin(RD | AS, 8'h05, 0);
    chk("dma shift", 8'h33, b);
    pin(SER | AS, 8'h00, 8'h02);
    pin(SER | RD | AS, 8'h10, 0);
    chk("shift left", 8'h3c, b);
    print_verdict();
  end
endmodule // serial_ctrl_host_bus_interface_test
`default_nettype wire
